// >>> pkg/fwu_pkg.sv
// package for the firmware update mode command interpreter
package fwu_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_PROP = 8'h0C;
    localparam logic [7:0] OFS_RESULT = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFS_PASS = 8'h1C;
    localparam logic [7:0] OFS_PEND = 8'h20;
    localparam logic [7:0] OFS_TAIL = 8'h24;
    localparam logic [7:0] OFS_VER1 = 8'h28;
    localparam logic [7:0] OFS_VER2 = 8'h2C;
    // command codes written to the command register
    localparam logic [3:0] CMD_UPG_START = 4'h1;
    localparam logic [3:0] CMD_GET_CAP = 4'h2;
    localparam logic [3:0] CMD_SELF_TEST = 4'h3;
    localparam logic [3:0] CMD_GET_RESULT = 4'h4;
    localparam logic [3:0] CMD_STARTUP = 4'h5;
    localparam logic [3:0] CMD_SHUTDOWN = 4'h6;
    // response codes
    localparam logic [7:0] RC_OK = 8'h00;
    localparam logic [7:0] RC_VALUE = 8'h01;
    localparam logic [7:0] RC_NOT_READY = 8'h02;
    // property selectors
    localparam logic [15:0] PROP_FW_VER1 = 16'h0001;
    localparam logic [15:0] PROP_FW_VER2 = 16'h0002;
    localparam logic [15:0] PROP_MODES = 16'h0003;
    localparam logic [15:0] PROP_VENDOR = 16'h0100;
    // capability answer framing
    localparam logic [31:0] CAP_COUNT = 32'h0000_0001;
    localparam logic [15:0] CAP_SIZE = 16'h0004;
    // self-test bit positions
    localparam int BIT_P521 = 21;
    localparam int BIT_KDF = 18;
    localparam int BIT_AES = 17;
    localparam int BIT_SENSOR = 15;
    localparam int BIT_SHA512 = 6;
    localparam int BIT_SHA384 = 5;
    localparam int BIT_SHA256 = 4;
    localparam logic [31:0] TEST_MASK = 32'h0026_8070;
    localparam logic [31:0] BOOT_MASK = 32'h0006_8070;
    localparam int RESULT_BYTES = 11;
    // operation-mode codes
    localparam logic [7:0] OPMODE_NORMAL = 8'h00;
    localparam logic [7:0] OPMODE_FWU = 8'h02;
    localparam logic [7:0] VER2_TOP = 8'h00;
    // timing
    localparam int CLK_MHZ = 200;
    localparam int REGVALID_US = 500;
    localparam int BLACKOUT_FWU_US = 700;
    localparam int READY_OP_MS = 50;
    localparam int READY_FWU_MS = 140;
    localparam int REGVALID_CYC = REGVALID_US * CLK_MHZ;
    localparam int READY_OP_CYC = READY_OP_MS * 1000 * CLK_MHZ;
    localparam int READY_FWU_CYC = READY_FWU_MS * 1000 * CLK_MHZ;
    localparam int TEST_CYC = 16;
    // status bits
    localparam int ST_REGVALID = 0;
    localparam int ST_ESTAB = 1;
    localparam int ST_READY = 2;
    localparam int ST_FWU = 3;
    localparam int ST_BUSY = 4;
    localparam int ST_DONE = 5;
    // interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_READY = 1;
    localparam int IRQ_TEST = 2;
    localparam int IRQ_W = 3;
    // ctrl bits
    localparam int CTRL_ESTAB = 0;
    localparam int CTRL_FWU_BOOT = 1;
endpackage

// >>> src/fwu_timer.sv
// down counter giving a one-cycle done pulse after a loaded count
`timescale 1ns/1ps
module fwu_timer #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // control
    input wire logic load,
    input wire logic [W-1:0] count,
    // status
    output logic running,
    output logic done
);
    logic [W-1:0] cnt_reg;
    logic run_reg;
    logic done_reg;

    // count down; load restarts
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (load) begin
            cnt_reg <= count;
            run_reg <= 1'b1;
            done_reg <= 1'b0;
        end else if (run_reg) begin
            done_reg <= (cnt_reg == W'(1));
            run_reg <= (cnt_reg != W'(1));
            cnt_reg <= cnt_reg - W'(1);
        end else begin
            done_reg <= 1'b0;
        end
    end

    assign running = run_reg;
    assign done = done_reg;
endmodule

// >>> src/fwu_cmd.sv
// command interpreter for firmware update mode, reset readiness and version props
// Operation
// - upgrade start success enters update mode
// - capability read returns single value
// - serve general minus modes, plus vendor
// - self-test in update mode reruns all upgrade tests
// - test result is eleven bytes
// - test bit one means passed
// - fixed self-test bit positions
// - P521 test only boot or request
// - startup/shutdown accepted, no state change in update mode
// - flags valid within 500 us
// - ready after 50 or 140 ms
// - version one is major, minor
// - version two is zero, build, cert
`timescale 1ns/1ps
module fwu_cmd #(
    parameter int REGVALID_CYC = fwu_pkg::REGVALID_CYC,
    parameter int READY_OP_CYC = fwu_pkg::READY_OP_CYC,
    parameter int READY_FWU_CYC = fwu_pkg::READY_FWU_CYC,
    parameter logic [15:0] FW_MAJOR = 16'h0001,
    parameter logic [15:0] FW_MINOR = 16'h0002,
    parameter logic [15:0] FW_BUILD = 16'h0003,
    parameter logic [7:0] CERT_STATE = 8'h00,
    parameter logic [31:0] VENDOR_PROP = 32'h0000_0000 // value is arbitrary
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // sensor self-test result, from pin
    input wire logic sensor_ok_pin,
    // flags and interrupt
    output logic establishment_flag,
    output logic register_valid_flag,
    output logic irq
);
    logic [31:0] ver1;
    logic [31:0] ver2;
    logic [31:0] ver2_alt_hi;
    logic sens_s1_reg;
    logic sens_s2_reg;
    localparam int IRQ_W_L = fwu_pkg::IRQ_W;
    logic fwu_reg;
    // power-up value only; nrst must not clear the update-mode latch
    logic fwu_boot_reg = 1'b0;
    logic estab_reg;
    logic regvalid_reg;
    logic ready_reg;
    logic started_reg;
    logic busy_reg;
    logic done_reg;
    logic [7:0] rc_reg;
    logic [3:0] cmd_reg;
    logic [15:0] prop_reg;
    logic [31:0] prop_val_reg;
    logic [31:0] pass_reg;
    logic [31:0] pend_reg;
    logic [15:0] info_reg;
    logic [7:0] mode_byte_reg;
    logic [31:0] ctrl_reg;
    logic [IRQ_W_L-1:0] irq_stat_reg;
    logic [IRQ_W_L-1:0] irq_mask_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rdata_reg;
    logic tload;
    logic [31:0] tcount;
    logic trun;
    logic tdone;
    logic addr_ok;
    logic wr_fire;
    logic cmd_go;
    logic test_done;
    logic ready_evt;

    typedef enum {ST_RESET, ST_REGWAIT, ST_BOOTWAIT, ST_IDLE, ST_TEST} fwu_state_t;
    fwu_state_t state_reg;

    assign ver1 = {FW_MAJOR, FW_MINOR};
    assign ver2 = {fwu_pkg::VER2_TOP, FW_BUILD, CERT_STATE};
    assign ver2_alt_hi = 32'h0000_0000;

    // ahb: address phase sampled, write done in data phase, zero waits
    assign addr_ok = hsel && hready && htrans[1];
    assign wr_fire = wr_pend_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    assign cmd_go = wr_fire && (wr_addr_reg == fwu_pkg::OFS_CMD);

    // sensor pin synchroniser; only the second stage is used
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sens_s1_reg <= 1'b0;
            sens_s2_reg <= 1'b0;
        end else begin
            sens_s1_reg <= sensor_ok_pin;
            sens_s2_reg <= sens_s1_reg;
        end
    end

    // write address capture
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr;
        end
    end

    // software control register
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl_reg <= 32'h0000_0000;
            prop_reg <= 16'h0000;
        end else if (wr_fire && wr_addr_reg == fwu_pkg::OFS_CTRL) begin
            ctrl_reg <= hwdata;
        end else if (wr_fire && wr_addr_reg == fwu_pkg::OFS_PROP) begin
            prop_reg <= hwdata[15:0];
        end
    end

    fwu_timer #(.W(32)) u_timer (
        .mclk(mclk),
        .nrst(nrst),
        .load(tload),
        .count(tcount),
        .running(trun),
        .done(tdone)
    );

    // timer loading per state
    always_comb begin
        tload = 1'b0;
        tcount = 32'h0000_0000;
        unique case (state_reg)
            ST_RESET: begin
                tload = 1'b1;
                tcount = 32'(REGVALID_CYC);
            end
            ST_REGWAIT: begin
                tload = tdone;
                tcount = fwu_reg ? 32'(READY_FWU_CYC - REGVALID_CYC)
                                 : 32'(READY_OP_CYC - REGVALID_CYC);
            end
            ST_IDLE: begin
                tload = cmd_go && hwdata[3:0] == fwu_pkg::CMD_SELF_TEST && fwu_reg;
                tcount = 32'(fwu_pkg::TEST_CYC);
            end
            default: begin
                tload = 1'b0;
            end
        endcase
    end

    assign test_done = (state_reg == ST_TEST) && tdone;
    assign ready_evt = (state_reg == ST_BOOTWAIT) && tdone;

    // reset sequence and command state
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_reg <= ST_RESET;
        end else begin
            unique case (state_reg)
                ST_RESET: state_reg <= ST_REGWAIT;
                ST_REGWAIT: if (tdone) state_reg <= ST_BOOTWAIT;
                // ready at 50 or 140 ms
                ST_BOOTWAIT: if (tdone) state_reg <= ST_IDLE;
                ST_IDLE: if (tload) state_reg <= ST_TEST;
                ST_TEST: if (tdone) state_reg <= ST_IDLE;
            endcase
        end
    end

    // mode strap caught after release; update mode held across the session
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            fwu_reg <= 1'b0;
        end else if (state_reg == ST_RESET) begin
            fwu_reg <= fwu_boot_reg;
        end else if (cmd_go && state_reg == ST_IDLE && !fwu_reg
                     && hwdata[3:0] == fwu_pkg::CMD_UPG_START) begin
            fwu_reg <= 1'b1;
        end
    end

    // boot latch has no reset branch, so update mode outlives nrst
    always_ff @(posedge mclk) begin
        if (nrst && cmd_go && state_reg == ST_IDLE && !fwu_reg
            && hwdata[3:0] == fwu_pkg::CMD_UPG_START) begin
            fwu_boot_reg <= 1'b1;
        end else if (nrst && wr_fire && wr_addr_reg == fwu_pkg::OFS_CTRL) begin
            fwu_boot_reg <= hwdata[fwu_pkg::CTRL_FWU_BOOT];
        end
    end

    // establishment and register-valid flags
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            estab_reg <= 1'b0;
            regvalid_reg <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            if (state_reg == ST_REGWAIT && tdone) begin
                estab_reg <= ctrl_reg[fwu_pkg::CTRL_ESTAB];
                regvalid_reg <= 1'b1;
            end
            if (ready_evt) ready_reg <= 1'b1;
        end
    end
    assign establishment_flag = estab_reg;
    assign register_valid_flag = regvalid_reg;

    // command execution
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rc_reg <= fwu_pkg::RC_OK;
            cmd_reg <= 4'h0;
            prop_val_reg <= 32'h0000_0000;
            done_reg <= 1'b0;
            started_reg <= 1'b0;
            mode_byte_reg <= fwu_pkg::OPMODE_NORMAL;
        end else if (cmd_go) begin
            cmd_reg <= hwdata[3:0];
            done_reg <= 1'b1;
            rc_reg <= fwu_pkg::RC_OK;
            if (state_reg != ST_IDLE) begin
                rc_reg <= fwu_pkg::RC_NOT_READY;
            end else begin
                unique case (hwdata[3:0])
                    fwu_pkg::CMD_GET_CAP: begin
                        if (prop_reg == fwu_pkg::PROP_FW_VER1) prop_val_reg <= ver1;
                        else if (prop_reg == fwu_pkg::PROP_FW_VER2) prop_val_reg <= ver2;
                        else if (prop_reg == fwu_pkg::PROP_VENDOR) prop_val_reg <= VENDOR_PROP;
                        else begin
                            prop_val_reg <= 32'h0000_0000;
                            rc_reg <= fwu_pkg::RC_VALUE;
                        end
                    end
                    fwu_pkg::CMD_GET_RESULT: begin
                        mode_byte_reg <= fwu_reg ? fwu_pkg::OPMODE_FWU
                                                 : fwu_pkg::OPMODE_NORMAL;
                    end
                    // accepted, nothing changes in update mode
                    fwu_pkg::CMD_STARTUP,
                    fwu_pkg::CMD_SHUTDOWN: begin
                        if (!fwu_reg) started_reg <= hwdata[3:0] == fwu_pkg::CMD_STARTUP;
                    end
                    default: begin
                        if (hwdata[3:0] == fwu_pkg::CMD_UPG_START && fwu_reg)
                            rc_reg <= fwu_pkg::RC_VALUE;
                    end
                endcase
            end
        end else if (wr_fire && wr_addr_reg == fwu_pkg::OFS_STATUS
                     && hwdata[fwu_pkg::ST_DONE]) begin
            done_reg <= 1'b0;
        end
    end

    // capability answer is the counted list with a single sized buffer
    // self-test result words
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pass_reg <= 32'h0000_0000;
            pend_reg <= fwu_pkg::TEST_MASK;
            info_reg <= 16'h0000;
        end else if (ready_evt) begin
            // boot tests; P521 only when booting in update mode
            // P521 at boot or request
            pass_reg <= (fwu_reg ? fwu_pkg::TEST_MASK : fwu_pkg::BOOT_MASK)
                        & ~(sens_s2_reg ? 32'h0 : (32'h1 << fwu_pkg::BIT_SENSOR));
            pend_reg <= fwu_reg ? 32'h0 : (32'h1 << fwu_pkg::BIT_P521);
        end else if (tload && state_reg == ST_IDLE) begin
            pass_reg <= 32'h0000_0000;
            pend_reg <= fwu_pkg::TEST_MASK;
        end else if (test_done) begin
            pass_reg <= fwu_pkg::TEST_MASK
                        & ~(sens_s2_reg ? 32'h0 : (32'h1 << fwu_pkg::BIT_SENSOR));
            pend_reg <= 32'h0000_0000;
            info_reg <= info_reg + 16'h0001;
        end
    end

    // sticky interrupt status, write one clears, set wins
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg
                & ~((wr_fire && wr_addr_reg == fwu_pkg::OFS_IRQ_STAT)
                    ? hwdata[IRQ_W_L-1:0] : '0))
                | {test_done, ready_evt, cmd_go};
            if (wr_fire && wr_addr_reg == fwu_pkg::OFS_IRQ_MASK)
                irq_mask_reg <= hwdata[IRQ_W_L-1:0];
        end
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // read data register, loaded in address phase
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            unique case (haddr)
                fwu_pkg::OFS_CTRL: rdata_reg <= ctrl_reg;
                fwu_pkg::OFS_STATUS: rdata_reg <= {26'h0, done_reg, state_reg == ST_TEST,
                    fwu_reg, ready_reg, estab_reg, regvalid_reg};
                fwu_pkg::OFS_CMD: rdata_reg <= {20'h0, rc_reg, cmd_reg};
                fwu_pkg::OFS_PROP: rdata_reg <= prop_val_reg;
                fwu_pkg::OFS_RESULT: rdata_reg <= {fwu_pkg::CAP_COUNT[15:0], fwu_pkg::CAP_SIZE};
                fwu_pkg::OFS_IRQ_STAT: rdata_reg <= {29'h0, irq_stat_reg};
                fwu_pkg::OFS_IRQ_MASK: rdata_reg <= {29'h0, irq_mask_reg};
                fwu_pkg::OFS_PASS: rdata_reg <= pass_reg;
                fwu_pkg::OFS_PEND: rdata_reg <= pend_reg;
                fwu_pkg::OFS_TAIL: rdata_reg <= {8'h0, info_reg, mode_byte_reg};
                fwu_pkg::OFS_VER1: rdata_reg <= ver1;
                fwu_pkg::OFS_VER2: rdata_reg <= ver2 | ver2_alt_hi;
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    chk_regvalid_time: assert property (@(posedge mclk) disable iff (!nrst)
        (state_reg == ST_REGWAIT && tdone) |=> register_valid_flag)
        else $error("register valid flag not set");
    chk_ver2_top: assert property (@(posedge mclk) disable iff (!nrst)
        ver2[31:24] == 8'h00)
        else $error("version two top byte not zero");
    chk_ver1_layout: assert property (@(posedge mclk) disable iff (!nrst)
        ver1[31:16] == FW_MAJOR && ver1[15:0] == FW_MINOR)
        else $error("version one layout wrong");
    chk_rsvd_zero: assert property (@(posedge mclk) disable iff (!nrst)
        (pass_reg & ~fwu_pkg::TEST_MASK) == 32'h0)
        else $error("reserved pass bit set");
    chk_test_rerun: assert property (@(posedge mclk) disable iff (!nrst)
        (state_reg == ST_IDLE && tload) |=> pend_reg == fwu_pkg::TEST_MASK)
        else $error("self-test not rerun");
    chk_p521_pend: assert property (@(posedge mclk) disable iff (!nrst)
        (ready_evt && !fwu_reg) |=> pend_reg[fwu_pkg::BIT_P521])
        else $error("p521 ran outside boot or request");
    chk_fwu_enter: assert property (@(posedge mclk) disable iff (!nrst)
        (cmd_go && state_reg == ST_IDLE && hwdata[3:0] == fwu_pkg::CMD_UPG_START)
        |=> fwu_reg)
        else $error("update mode not entered");
    chk_stub_cmds: assert property (@(posedge mclk) disable iff (!nrst)
        (cmd_go && fwu_reg && (hwdata[3:0] == fwu_pkg::CMD_STARTUP
         || hwdata[3:0] == fwu_pkg::CMD_SHUTDOWN)) |=> $stable(started_reg))
        else $error("startup or shutdown changed state");
endmodule

// >>> verif/fwu_host.sv
// host platform model: ahb-lite master issuing register transfers
`timescale 1ns/1ps
module fwu_host (
    // clock
    input wire logic mclk,
    // ahb-lite master outputs
    output logic hsel,
    output logic [7:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // slave answer
    input wire logic hreadyout,
    input wire logic [31:0] hrdata
);
    // idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // one single word transfer; waits on hready, no fixed latency assumed
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
        // released data line must not keep the last value
        hwdata <= ~d;
    endtask

    // register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask

    // register read
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        xfer(a, 1'b0, 32'h0000_0000, r);
    endtask
endmodule

// >>> verif/fw_update_mode_cmd_and_reset_ready_tb.sv
// self-checking bench for the update mode command interpreter
`timescale 1ns/1ps
module fw_update_mode_cmd_and_reset_ready_tb;
    localparam int RV = 20;
    localparam int ROP = 100;
    localparam int RFW = 200;
    localparam logic [15:0] MAJ = 16'h000F;
    localparam logic [15:0] MIN = 16'h000C;
    localparam logic [15:0] BLD = 16'h3D3F;
    localparam logic [7:0] CST = 8'h02;
    localparam logic [31:0] VND = 32'h5A5A_1234; // value is arbitrary
    logic mclk, nrst, hsel, hwrite, hreadyout, sensor_ok_pin;
    logic establishment_flag, register_valid_flag, irq;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, r, s0, p0, ex;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int rel;
    int tbits[7] = '{21, 18, 17, 15, 6, 5, 4};
    logic [15:0] sels[5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0100, 16'h0007};

    fwu_cmd #(.REGVALID_CYC(RV), .READY_OP_CYC(ROP), .READY_FWU_CYC(RFW),
        .FW_MAJOR(MAJ), .FW_MINOR(MIN), .FW_BUILD(BLD), .CERT_STATE(CST),
        .VENDOR_PROP(VND)) u_fwu_cmd (.mclk(mclk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(),
        .hrdata(hrdata), .sensor_ok_pin(sensor_ok_pin),
        .establishment_flag(establishment_flag),
        .register_valid_flag(register_valid_flag), .irq(irq));
    fwu_host u_fwu_host (.mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hreadyout(hreadyout),
        .hrdata(hrdata));

    // clock, 5 ns period
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // cycle count and hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic final_report();
        if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // reset, flag timing, host blackout, then poll for ready
    task automatic do_reset(input int rdy, input int blk, input bit probe);
        int n;
        nrst <= 1'b0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        rel = cyc;
        for (n = 0; n < 100 && register_valid_flag !== 1'b1; n++) @(posedge mclk);
        chk("regvalid_time", 32'(cyc - rel >= RV && cyc - rel <= RV + 5), 1);
        chk("estab_flag", 32'(establishment_flag), 0);
        while (cyc - rel < blk) @(posedge mclk);
        if (probe) begin
            u_fwu_host.wr(fwu_pkg::OFS_CMD, 32'(fwu_pkg::CMD_GET_CAP));
            u_fwu_host.rd(fwu_pkg::OFS_CMD, r);
            chk("rc_not_ready", 32'(r[11:4]), 32'(fwu_pkg::RC_NOT_READY));
        end
        for (n = 0; n < 200; n++) begin
            u_fwu_host.rd(fwu_pkg::OFS_STATUS, r);
            if (r[2] === 1'b1) break;
        end
        chk("ready_time", 32'(cyc - rel >= rdy && cyc - rel <= rdy + 12), 1);
    endtask

    // command issue, wait for done, interrupt then clear
    task automatic run(input logic [3:0] c, input logic m);
        int n;
        u_fwu_host.wr(fwu_pkg::OFS_CMD, 32'(c));
        for (n = 0; n < 100; n++) begin
            u_fwu_host.rd(fwu_pkg::OFS_STATUS, r);
            if (r[5] === 1'b1 && r[4] === 1'b0) break;
        end
        chk("cmd_done", 32'(r[5]), 1);
        chk("irq_done", 32'(irq), 32'(m));
        u_fwu_host.wr(fwu_pkg::OFS_STATUS, 32'h0000_0020);
        u_fwu_host.wr(fwu_pkg::OFS_IRQ_STAT, 32'h0000_0007);
        u_fwu_host.rd(fwu_pkg::OFS_STATUS, r);
        chk("irq_clear", 32'(irq), 0);
    endtask

    // main sequence
    initial begin
        nrst = 1'b0;
        sensor_ok_pin = 1'b1;
        r = $urandom(32'hd1d02281);
        do_reset(ROP, RV, 1'b1);
        u_fwu_host.wr(fwu_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        u_fwu_host.rd(fwu_pkg::OFS_STATUS, r);
        chk("irq_masked", 32'(irq), 0);
        u_fwu_host.wr(fwu_pkg::OFS_IRQ_MASK, 32'h0000_0002);
        u_fwu_host.rd(fwu_pkg::OFS_STATUS, r);
        chk("irq_ready", 32'(irq), 1);
        chk("fwu_off", 32'(r[3]), 0);
        u_fwu_host.wr(fwu_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        u_fwu_host.wr(8'h40, $urandom);
        u_fwu_host.rd(8'h40, r);
        chk("unmapped", r, 0);
        run(fwu_pkg::CMD_UPG_START, 1'b1);
        u_fwu_host.rd(fwu_pkg::OFS_STATUS, s0);
        chk("fwu_on", 32'(s0[3]), 1);
        u_fwu_host.rd(fwu_pkg::OFS_PASS, p0);
        run(fwu_pkg::CMD_STARTUP, 1'b1);
        run(fwu_pkg::CMD_SHUTDOWN, 1'b1);
        u_fwu_host.rd(fwu_pkg::OFS_STATUS, r);
        chk("no_effect_st", r & 32'hF, s0 & 32'hF);
        u_fwu_host.rd(fwu_pkg::OFS_PASS, r);
        chk("no_effect_pass", r, p0);
        // command finished before reset, so no security reaction
        do_reset(RFW, RV * 700 / 500, 1'b0);
        u_fwu_host.wr(fwu_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        u_fwu_host.rd(fwu_pkg::OFS_STATUS, r);
        chk("fwu_kept", 32'(r[3]), 1);
        foreach (sels[i]) begin
            u_fwu_host.wr(fwu_pkg::OFS_PROP, 32'(sels[i]));
            run(fwu_pkg::CMD_GET_CAP, 1'b1);
            u_fwu_host.rd(fwu_pkg::OFS_CMD, r);
            ex = (i == 2 || i == 4) ? 32'(fwu_pkg::RC_VALUE) : 32'(fwu_pkg::RC_OK);
            chk("cap_rc", 32'(r[11:4]), ex);
            if (i != 2 && i != 4) begin
                u_fwu_host.rd(fwu_pkg::OFS_RESULT, r);
                chk("cap_list", r, 32'h0001_0004);
                u_fwu_host.rd(fwu_pkg::OFS_PROP, r);
                ex = (i == 0) ? {MAJ, MIN} : (i == 1) ? {8'h00, BLD, CST} : VND;
                chk("prop_val", r, ex);
                if (i == 1) chk("ver2_half", 32'(r[31:16]), 32'({8'h00, BLD[15:8]}));
            end
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            sensor_ok_pin <= 1'($urandom);
            repeat (4) @(posedge mclk);
            ex = 0;
            foreach (tbits[j]) ex[tbits[j]] = (tbits[j] != 15) || sensor_ok_pin;
            run(fwu_pkg::CMD_SELF_TEST, 1'b1);
            run(fwu_pkg::CMD_GET_RESULT, 1'b1);
            u_fwu_host.rd(fwu_pkg::OFS_PASS, r);
            chk("pass_bits", r, ex);
            u_fwu_host.rd(fwu_pkg::OFS_PEND, r);
            chk("pend_bits", r, 0);
            u_fwu_host.rd(fwu_pkg::OFS_TAIL, r);
            chk("mode_byte", 32'(r[7:0]), 32'(fwu_pkg::OPMODE_FWU));
        end
        final_report();
    end
endmodule
